// File: cp_channel_regs.sv
// Register set of one serial channel.
module cp_channel_regs
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Access
    input  wire logic         sel,
    input  wire logic         write,
    input  wire logic [3:0]   offset,
    input  wire logic [15:0]  wdata,
    input  wire logic [7:0]   events_in,
    input  wire logic [7:0]   status_in,
    // Read data and state
    output logic [15:0]       rdata,
    output logic              hit,
    output logic [15:0]       mode
);

    logic [15:0] clock_config_reg;
    logic [15:0] mode_reg;
    logic [15:0] sync_reg;
    logic [7:0]  event_reg;
    logic [7:0]  mask_reg;

    assign mode = mode_reg;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            clock_config_reg <= cp_cmd_pkg::RST_WORD;
            mode_reg         <= cp_cmd_pkg::RST_WORD;
            sync_reg         <= cp_cmd_pkg::RST_SYNC_PATTERN;
            mask_reg         <= 8'h00;
        end
        else if (sel && write)
        begin
            unique case (offset)
                cp_cmd_pkg::OFF_CLOCK_CONFIG: clock_config_reg <= wdata;
                cp_cmd_pkg::OFF_CH_MODE:      mode_reg <= wdata;
                cp_cmd_pkg::OFF_SYNC_PATTERN: sync_reg <= wdata;
                cp_cmd_pkg::OFF_EVENT_MASK:   mask_reg <= wdata[15:8];
                default:
                begin
                end
            endcase
        end
    end

    // Event bits are cleared by writing ones; a new event wins over a clear.
    always_ff @(posedge mclk)
    begin
        if (rst)
            event_reg <= 8'h00;
        else if (sel && write && offset == cp_cmd_pkg::OFF_EVENT_FLAGS)
            event_reg <= (event_reg & ~wdata[15:8]) | events_in;
        else
            event_reg <= event_reg | events_in;
    end

    always_comb
    begin
        hit   = 1'b1;
        rdata = 16'h0000;
        unique case (offset)
            cp_cmd_pkg::OFF_CLOCK_CONFIG: rdata = clock_config_reg;
            cp_cmd_pkg::OFF_CH_MODE:      rdata = mode_reg;
            cp_cmd_pkg::OFF_SYNC_PATTERN: rdata = sync_reg;
            cp_cmd_pkg::OFF_EVENT_FLAGS:  rdata = {event_reg, 8'h00};
            cp_cmd_pkg::OFF_EVENT_MASK:   rdata = {mask_reg, 8'h00};
            cp_cmd_pkg::OFF_LINE_STATUS:  rdata = {status_in, 8'h00};
            default:                      hit = 1'b0;
        endcase
    end

endmodule

// File: cp_cmd_decode.sv
// Combinational decode of a command byte into a dispatch pulse.
module cp_cmd_decode
(
    // Command
    input  wire cp_cmd_pkg::command_t  cmd,
    input  wire logic                  fire,
    // Result
    output cp_cmd_pkg::dispatch_t      dispatch
);

    always_comb
    begin
        dispatch        = '0;
        dispatch.gci    = cmd.gci;
        dispatch.opcode = cmd.opcode;
        // Code 11 selects no channel, so the command does nothing.
        unique case (cmd.channel_select)
            2'b00: dispatch.channel_onehot = 3'b001;
            2'b01: dispatch.channel_onehot = 3'b010;
            2'b10: dispatch.channel_onehot = 3'b100;
            2'b11: dispatch.channel_onehot = 3'b000;
        endcase
        dispatch.valid = fire && (dispatch.channel_onehot != 3'b000);
    end

endmodule

// File: cp_cmd_pkg.sv
// Package with register map, field positions and types of the command block.
package cp_cmd_pkg;

    localparam int unsigned ADDR_W = 12;

    // Register offsets: 12-bit ones are byte addresses from the device base, 4-bit ones lie within a channel register set.
    localparam logic [11:0] OFF_COMMAND       = 12'h0860;
    localparam logic [11:0] OFF_SLOT_MASK     = 12'h08b2;
    localparam logic [11:0] OFF_IF_MODE       = 12'h08b4;
    localparam logic [11:0] OFF_CH1_REGS      = 12'h0880;
    localparam logic [11:0] OFF_CH2_REGS      = 12'h0890;
    localparam logic [11:0] OFF_CH3_REGS      = 12'h08a0;
    localparam logic [11:0] OFF_CH1_PRAM      = 12'h0400;
    localparam logic [11:0] OFF_CH2_PRAM      = 12'h0500;
    localparam logic [11:0] OFF_CH3_PRAM      = 12'h0600;
    localparam logic [11:0] OFF_PARAM_BASE    = 12'h0080;
    localparam logic [11:0] OFF_PRAM_SPAN     = 12'h0100;
    localparam logic [3:0]  OFF_CLOCK_CONFIG  = 4'h2;
    localparam logic [3:0]  OFF_CH_MODE       = 4'h4;
    localparam logic [3:0]  OFF_SYNC_PATTERN  = 4'h6;
    localparam logic [3:0]  OFF_EVENT_FLAGS   = 4'h8;
    localparam logic [3:0]  OFF_EVENT_MASK    = 4'ha;
    localparam logic [3:0]  OFF_LINE_STATUS   = 4'hc;

    // Command register fields.
    localparam int unsigned CMD_PENDING_BIT = 0;
    localparam int unsigned CMD_CHAN_LSB    = 1;
    localparam int unsigned CMD_RSVD_BIT    = 3;
    localparam int unsigned CMD_OP_LSB      = 4;
    localparam int unsigned CMD_GCI_BIT     = 6;
    localparam int unsigned CMD_RESET_BIT   = 7;

    // Interface mode fields.
    localparam int unsigned MODE_FORCE_LOW_BIT = 15;
    localparam int unsigned MODE_SYNC_FORM_BIT = 14;
    localparam logic [1:0]  IF_GCI             = 2'h3;

    // Reset values.
    localparam logic [7:0]  RST_COMMAND      = 8'h00;
    localparam logic [15:0] RST_WORD         = 16'h0000;
    localparam logic [15:0] RST_SYNC_PATTERN = 16'h7e7e;

    // Command processing time in clock cycles.
    localparam int unsigned EXEC_TIME_NS  = 40;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned EXEC_CYCLES   = (EXEC_TIME_NS + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
    localparam int unsigned SRESET_CYCLES = 8;

    typedef enum logic [1:0] {
        OP_STOP_TX,
        OP_RESTART_TX,
        OP_ENTER_HUNT,
        OP_RESET_RX_BCS
    } opcode_t;

    typedef struct packed {
        logic        soft_reset;
        logic        gci;
        opcode_t     opcode;
        logic        reserved;
        logic [1:0]  channel_select;
        logic        command_pending_flag;
    } command_t;

    // One command pulse towards the serial channels.
    typedef struct packed {
        logic        valid;
        logic        gci;
        opcode_t     opcode;
        logic [2:0]  channel_onehot;
    } dispatch_t;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [11:0] addr;
        logic [15:0] wdata;
    } bus_req_t;

endpackage

// File: cp_cmd_props.sv
// Port checker of the command block.
module cp_cmd_props
(
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  rst,
    // Register port
    input wire logic [11:0]           addr,
    input wire logic [15:0]           wdata,
    input wire logic                  wr,
    input wire logic                  rd,
    input wire logic [15:0]           rdata,
    // Channel side
    input wire logic                  layer_one_tx_src,
    input wire cp_cmd_pkg::dispatch_t dispatch,
    input wire logic                  soft_reset_active,
    input wire logic                  layer_one_tx_data,
    input wire logic                  sync_pulse_form,
    input wire logic [15:0]           serial_slot_bit_mask,
    input wire logic [15:0]           serial_interface_mode
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic       cmd_wr;
    logic       force_on;
    logic [1:0] age_reg;

    assign cmd_wr   = wr && addr == 12'h0860;
    assign force_on = serial_interface_mode[15]
                      && serial_interface_mode[1:0] == cp_cmd_pkg::IF_GCI;

    // Masks the cycles in which outputs still show their reset levels.
    always_ff @(posedge mclk)
    begin
        if (rst)
            age_reg <= 2'h0;
        else if (age_reg != 2'h3)
            age_reg <= age_reg + 2'h1;
    end

    a_rdata_idle_zero: assert property (
        !$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    a_dispatch_cause: assert property (
        dispatch.valid |-> $past(cmd_wr && wdata[8] && !wdata[15], 5))
        else $error("dispatch without a command write five cycles before");
    a_dispatch_fields: assert property (
        dispatch.valid |-> dispatch.opcode == $past(wdata[13:12], 5)
        && dispatch.gci == $past(wdata[14], 5)
        && dispatch.channel_onehot == 3'(3'b001 << $past(wdata[10:9], 5)))
        else $error("dispatch fields differ from the command written");
    a_dispatch_pulse: assert property (
        dispatch.valid |=> !dispatch.valid)
        else $error("dispatch valid longer than one cycle");
    a_reset_starts: assert property (
        cmd_wr && wdata[15] && !soft_reset_active |-> ##[1:3] soft_reset_active)
        else $error("software reset did not start");
    a_reset_length: assert property (
        $rose(soft_reset_active)
        |-> soft_reset_active[*7] ##[1:4] !soft_reset_active)
        else $error("software reset sequence of wrong length");
    a_reset_clears: assert property (
        $fell(soft_reset_active) |-> serial_interface_mode == 16'h0000
        && serial_slot_bit_mask == 16'h0000)
        else $error("software reset left configuration set");
    a_force_low_gci: assert property (
        age_reg == 2'h3 ##0 $stable(serial_interface_mode)[*2] ##0 force_on
        |-> !layer_one_tx_data)
        else $error("layer one transmit not forced low");
    a_tx_follows_src: assert property (
        age_reg == 2'h3 ##0 ($stable(serial_interface_mode)
        && $stable(layer_one_tx_src))[*2] ##0 !force_on
        |-> layer_one_tx_data == layer_one_tx_src)
        else $error("layer one transmit does not follow its source");
    a_sync_form_copy: assert property (
        $stable(serial_interface_mode)[*2]
        |-> sync_pulse_form == serial_interface_mode[14])
        else $error("sync form output differs from mode bit");

    c_dispatch: cover property (dispatch.valid);
    c_soft_reset: cover property ($rose(soft_reset_active));
    c_force_low: cover property (layer_one_tx_src && !layer_one_tx_data);
endmodule

bind cp_command_and_serial_config cp_cmd_props props_i
(
    .mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .layer_one_tx_src,
    .dispatch, .soft_reset_active, .layer_one_tx_data, .sync_pulse_form,
    .serial_slot_bit_mask, .serial_interface_mode
);

// File: cp_command_and_serial_config.sv
// Command interpreter and shared serial configuration of the processor.
//
// Overview of operation
// - Command register is 8 bits at 0x860 on the upper data byte.
// - Processor clears the pending flag when processing ends, ready for next.
// - Reset bit starts a software reset; the processor clears it then.
// - GCI bit makes opcode a GCI command; host uses channel 10, flag 1.
// - Opcodes: stop tx, restart tx, enter hunt, reset rx check generator.
// - One shared set of interface registers serves all three channels.
// - Sixteen-bit interface mode register sits at 0x8B4.
// - Mode bit 15 forces layer one transmit data low, in GCI only.
// - Mode bit 14 picks single sync pulse or N-bit wide sync.
// - Channel parameter RAM at base plus 0x400, 0x500, 0x600.
// - Channel register sets at base plus 0x880, 0x890, 0x8A0.
module cp_command_and_serial_config
#(
    parameter int unsigned PRAM_WORDS = 128
)
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Register port
    input  wire logic [11:0]  addr,
    input  wire logic [15:0]  wdata,
    input  wire logic         wr,
    input  wire logic         rd,
    output logic [15:0]       rdata,
    // Channel side
    input  wire logic [23:0]  channel_events,
    input  wire logic [23:0]  channel_status,
    input  wire logic         layer_one_tx_src,
    output cp_cmd_pkg::dispatch_t dispatch,
    output logic              soft_reset_active,
    output logic              layer_one_tx_data,
    output logic              sync_pulse_form,
    output logic [15:0]       serial_slot_bit_mask,
    output logic [15:0]       serial_interface_mode
);

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RESET} cp_state_t;

    cp_state_t            state_reg;
    cp_cmd_pkg::command_t command_reg;
    logic [15:0]          slot_mask_reg;
    logic [15:0]          if_mode_reg;
    logic [3:0]           count_reg;
    logic [15:0]          rdata_reg;
    logic [15:0]          pram_mem [3*PRAM_WORDS];
    logic                 fire;
    logic                 cmd_write;
    cp_cmd_pkg::command_t cmd_wr;
    cp_cmd_pkg::dispatch_t dispatch_next;
    logic [2:0]           ch_sel;
    logic [2:0]           ch_hit;
    logic [15:0]          ch_rdata [3];
    logic [11:0]          pram_rel;
    logic                 pram_sel;
    logic [1:0]           pram_ch;
    localparam int unsigned PRAM_IDX_W = $clog2(3*PRAM_WORDS);
    logic [PRAM_IDX_W-1:0] pram_idx;
    logic                 layer_one_next;

    localparam logic [3:0] EXEC_LAST =
        4'(cp_cmd_pkg::EXEC_CYCLES - 1);
    localparam logic [3:0] SRESET_LAST =
        4'(cp_cmd_pkg::SRESET_CYCLES - 1);

    function automatic logic in_block(input logic [11:0] a,
                                      input logic [11:0] base);
        in_block = (a[11:4] == base[11:4]);
    endfunction

    assign cmd_write = wr && addr == cp_cmd_pkg::OFF_COMMAND;
    assign cmd_wr    = cp_cmd_pkg::command_t'(wdata[15:8]);

    // Channel register sets, one per channel.
    assign ch_sel[0] = in_block(addr, cp_cmd_pkg::OFF_CH1_REGS);
    assign ch_sel[1] = in_block(addr, cp_cmd_pkg::OFF_CH2_REGS);
    assign ch_sel[2] = in_block(addr, cp_cmd_pkg::OFF_CH3_REGS);

    for (genvar g = 0; g < 3; g++)
    begin : g_ch
        cp_channel_regs u_regs
        (
            .mclk      (mclk),
            .rst       (rst || state_reg == ST_RESET),
            .sel       (ch_sel[g]),
            .write     (wr),
            .offset    (addr[3:0]),
            .wdata     (wdata),
            .events_in (channel_events[g*8 +: 8]),
            .status_in (channel_status[g*8 +: 8]),
            .rdata     (ch_rdata[g]),
            .hit       (ch_hit[g]),
            .mode      ()
        );
    end

    // Parameter RAM windows at 0x400, 0x500 and 0x600.
    always_comb
    begin
        pram_sel = 1'b1;
        pram_ch  = 2'd0;
        pram_rel = addr - cp_cmd_pkg::OFF_CH1_PRAM;
        if (addr[11:8] == cp_cmd_pkg::OFF_CH1_PRAM[11:8])
            pram_ch = 2'd0;
        else if (addr[11:8] == cp_cmd_pkg::OFF_CH2_PRAM[11:8])
            pram_ch = 2'd1;
        else if (addr[11:8] == cp_cmd_pkg::OFF_CH3_PRAM[11:8])
            pram_ch = 2'd2;
        else
            pram_sel = 1'b0;
        pram_rel = {4'h0, addr[7:0]};
        if (32'(pram_rel[7:1]) >= PRAM_WORDS)
            pram_sel = 1'b0;
        pram_idx = PRAM_IDX_W'(pram_ch * PRAM_WORDS + pram_rel[7:1]);
    end

    always_ff @(posedge mclk)
    begin
        if (wr && pram_sel)
            pram_mem[pram_idx] <= wdata;
    end

    // Command decode into a channel pulse.
    assign fire = state_reg == ST_EXEC && count_reg == EXEC_LAST;

    cp_cmd_decode u_dec
    (
        .cmd      (command_reg),
        .fire     (fire),
        .dispatch (dispatch_next)
    );

    // Command state machine.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_reg   <= ST_IDLE;
            command_reg <= cp_cmd_pkg::command_t'(cp_cmd_pkg::RST_COMMAND);
            count_reg   <= 4'h0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    count_reg <= 4'h0;
                    if (cmd_write)
                    begin
                        command_reg          <= cmd_wr;
                        command_reg.reserved <= 1'b0;
                        if (cmd_wr.soft_reset)
                            state_reg <= ST_RESET;
                        else if (cmd_wr.command_pending_flag)
                            state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    count_reg <= count_reg + 4'h1;
                    if (cmd_write && cmd_wr.soft_reset)
                    begin
                        command_reg <= cmd_wr;
                        count_reg   <= 4'h0;
                        state_reg   <= ST_RESET;
                    end
                    else if (fire)
                    begin
                        command_reg.command_pending_flag <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RESET:
                begin
                    count_reg <= count_reg + 4'h1;
                    if (count_reg == SRESET_LAST)
                    begin
                        command_reg <= cp_cmd_pkg::command_t'(
                            cp_cmd_pkg::RST_COMMAND);
                        state_reg   <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Shared interface registers for all channels.
    always_ff @(posedge mclk)
    begin
        if (rst || state_reg == ST_RESET)
        begin
            slot_mask_reg <= cp_cmd_pkg::RST_WORD;
            if_mode_reg   <= cp_cmd_pkg::RST_WORD;
        end
        else if (wr)
        begin
            if (addr == cp_cmd_pkg::OFF_SLOT_MASK)
                slot_mask_reg <= wdata;
            if (addr == cp_cmd_pkg::OFF_IF_MODE)
                if_mode_reg <= wdata;
        end
    end

    // Forced low only when the interface runs in GCI mode.
    assign layer_one_next =
        (if_mode_reg[cp_cmd_pkg::MODE_FORCE_LOW_BIT] &&
         if_mode_reg[1:0] == cp_cmd_pkg::IF_GCI) ? 1'b0
        : layer_one_tx_src;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            layer_one_tx_data     <= 1'b1;
            sync_pulse_form       <= 1'b0;
            serial_slot_bit_mask  <= cp_cmd_pkg::RST_WORD;
            serial_interface_mode <= cp_cmd_pkg::RST_WORD;
            dispatch              <= '0;
            soft_reset_active     <= 1'b0;
        end
        else
        begin
            layer_one_tx_data     <= layer_one_next;
            sync_pulse_form       <=
                if_mode_reg[cp_cmd_pkg::MODE_SYNC_FORM_BIT];
            serial_slot_bit_mask  <= slot_mask_reg;
            serial_interface_mode <= if_mode_reg;
            dispatch              <= dispatch_next;
            soft_reset_active     <= state_reg == ST_RESET;
        end
    end

    // Read path, data one cycle after the strobe.
    always_ff @(posedge mclk)
    begin
        if (rst)
            rdata_reg <= 16'h0000;
        else if (rd)
        begin
            if (addr == cp_cmd_pkg::OFF_COMMAND)
                rdata_reg <= {command_reg, 8'h00};
            else if (addr == cp_cmd_pkg::OFF_SLOT_MASK)
                rdata_reg <= slot_mask_reg;
            else if (addr == cp_cmd_pkg::OFF_IF_MODE)
                rdata_reg <= if_mode_reg;
            else if (ch_sel[0] && ch_hit[0])
                rdata_reg <= ch_rdata[0];
            else if (ch_sel[1] && ch_hit[1])
                rdata_reg <= ch_rdata[1];
            else if (ch_sel[2] && ch_hit[2])
                rdata_reg <= ch_rdata[2];
            else if (pram_sel)
                rdata_reg <= pram_mem[pram_idx];
            else
                rdata_reg <= 16'h0000;
        end
        else
            rdata_reg <= 16'h0000;
    end

    assign rdata = rdata_reg;

endmodule

// File: tb_cp_command_and_serial_config.sv
// Self-checking bench of the command block.
module tb_cp_command_and_serial_config;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  mclk;
    logic                  rst;
    logic [11:0]           addr;
    logic [15:0]           wdata;
    logic                  wr;
    logic                  rd;
    logic [15:0]           rdata;
    logic [23:0]           channel_events;
    logic [23:0]           channel_status;
    logic                  layer_one_tx_src;
    cp_cmd_pkg::dispatch_t dispatch;
    logic                  soft_reset_active;
    logic                  layer_one_tx_data;
    logic                  sync_pulse_form;
    logic [15:0]           serial_slot_bit_mask;
    logic [15:0]           serial_interface_mode;
    int                    err_count;
    int                    tests_run;

    cp_command_and_serial_config #(.PRAM_WORDS(128)) uut
    (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .channel_events(channel_events),
        .channel_status(channel_status), .dispatch(dispatch),
        .layer_one_tx_src(layer_one_tx_src),
        .soft_reset_active(soft_reset_active),
        .layer_one_tx_data(layer_one_tx_data),
        .sync_pulse_form(sync_pulse_form),
        .serial_slot_bit_mask(serial_slot_bit_mask),
        .serial_interface_mode(serial_interface_mode)
    );

    // ------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------
    task automatic close_out();
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_up();
        err_count++;
        close_out();
    endtask

    task automatic wreg(input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [15:0] exp);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic wait_disp(output cp_cmd_pkg::dispatch_t d);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge mclk);
            #1;
            if (dispatch.valid === 1'b1)
            begin
                d = dispatch;
                return;
            end
        end
        give_up();
    endtask

    // Polls the pending flag before the next command is issued.
    task automatic wait_idle();
        for (int i = 0; i < 20; i++)
        begin
            @(posedge mclk);
            rd   <= 1'b1;
            addr <= 12'h0860;
            @(posedge mclk);
            rd <= 1'b0;
            #1;
            if (rdata[8] === 1'b0)
                return;
        end
        give_up();
    endtask

    // Counts dispatch pulses over a fixed quiet window.
    task automatic count_disp(input int n, output int hits);
        hits = 0;
        repeat (n)
        begin
            @(posedge mclk);
            #1;
            if (dispatch.valid !== 1'b0)
                hits++;
        end
    endtask

    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 20; i++)
        begin
            @(posedge mclk);
            #1;
            if (soft_reset_active === lvl)
                return;
        end
        give_up();
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        rchk(12'h0860, 16'h0000);
        rchk(12'h08b4, 16'h0000);
        rchk(12'h08b2, 16'h0000);
        rchk(12'h0886, 16'h7e7e);
        rchk(12'h0ffe, 16'h0000);
    endtask

    task automatic t_all_commands();
        cp_cmd_pkg::dispatch_t d;
        int                    hits;
        for (int c = 0; c < 4; c++)
            for (int o = 0; o < 4; o++)
            begin
                wreg(12'h0860, {2'b00, o[1:0], 1'b0, c[1:0], 1'b1, 8'h00});
                rchk(12'h0860, {2'b00, o[1:0], 1'b0, c[1:0], 1'b1, 8'h00});
                if (c == 3)
                begin
                    count_disp(10, hits);
                    chk(16'(hits), 16'h0000);
                end
                else
                begin
                    wait_disp(d);
                    chk(16'(d), 16'({2'b10, o[1:0], 3'(3'b001 << c)}));
                end
                wait_idle();
            end
    endtask

    task automatic t_gci_and_overlap();
        cp_cmd_pkg::dispatch_t d;
        int                    hits;
        wreg(12'h0860, 16'h6500);
        wait_disp(d);
        chk(16'(d), 16'h0074);
        wait_idle();
        wreg(12'h0860, 16'h1100);
        wreg(12'h0860, 16'h3500);
        wait_disp(d);
        chk(16'(d), 16'h0049);
        count_disp(10, hits);
        chk(16'(hits), 16'h0000);
        wait_idle();
    endtask

    task automatic t_interface_mode();
        wreg(12'h08b4, 16'hc003);
        wreg(12'h08b2, 16'ha5c3);
        repeat (3) @(posedge mclk);
        #1;
        chk(16'(layer_one_tx_data), 16'h0000);
        chk(16'(sync_pulse_form), 16'h0001);
        chk(serial_slot_bit_mask, 16'ha5c3);
        chk(serial_interface_mode, 16'hc003);
        rchk(12'h08b4, 16'hc003);
        rchk(12'h08b2, 16'ha5c3);
        wreg(12'h08b4, 16'h8002);
        repeat (3) @(posedge mclk);
        #1;
        chk(16'(layer_one_tx_data), 16'h0001);
        chk(16'(sync_pulse_form), 16'h0000);
        @(posedge mclk);
        layer_one_tx_src <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk(16'(layer_one_tx_data), 16'h0000);
        @(posedge mclk);
        layer_one_tx_src <= 1'b1;
    endtask

    task automatic t_channel_map();
        for (int c = 0; c < 3; c++)
        begin
            wreg(12'h0886 + 12'(c * 16), 16'h1111 * 16'(c + 1));
            wreg(12'h0480 + 12'(c * 256), 16'h0c0d + 16'(c));
            wreg(12'h04b8 + 12'(c * 256), 16'h2222 * 16'(c + 1));
        end
        for (int c = 0; c < 3; c++)
        begin
            rchk(12'h0886 + 12'(c * 16), 16'h1111 * 16'(c + 1));
            rchk(12'h088c + 12'(c * 16), {channel_status[c*8 +: 8], 8'h00});
            rchk(12'h0480 + 12'(c * 256), 16'h0c0d + 16'(c));
            rchk(12'h04b8 + 12'(c * 256), 16'h2222 * 16'(c + 1));
        end
        @(posedge mclk);
        channel_events <= 24'h00_0100;
        @(posedge mclk);
        channel_events <= 24'h00_0000;
        rchk(12'h0898, 16'h0100);
        wreg(12'h0898, 16'h0100);
        rchk(12'h0898, 16'h0000);
    endtask

    task automatic t_soft_reset();
        wreg(12'h08b4, 16'hc003);
        wreg(12'h0884, 16'h0055);
        wreg(12'h0860, 16'h8100);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rchk(12'h0860, 16'h0000);
        rchk(12'h08b4, 16'h0000);
        rchk(12'h08b2, 16'h0000);
        rchk(12'h0884, 16'h0000);
        rchk(12'h0480, 16'h0c0d);
        // A reset request taken while a command still executes.
        wreg(12'h0860, 16'h1100);
        wreg(12'h0860, 16'h8100);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rchk(12'h0860, 16'h0000);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        rst              = 1'b1;
        wr               = 1'b0;
        rd               = 1'b0;
        addr             = 12'h000;
        wdata            = 16'h0000;
        channel_events   = 24'h00_0000;
        channel_status   = 24'h3c_5a96;
        layer_one_tx_src = 1'b1;
        err_count        = 0;
        tests_run        = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_reset_values();
        t_all_commands();
        t_gci_and_overlap();
        t_interface_mode();
        t_channel_map();
        t_soft_reset();
        close_out();
    end
endmodule
